//--- src/charger_detect_and_switch_sequencer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Bus-voltage flag rising in active mode starts supply-type detection.
// - First step waits a detection delay set by a programmable field.
// - During delay, if ID not open, wait ID-done then check for AV cable.
// - AV cable sets AV, attach irqs and AV type, ends; else probe.
// - Probe raises detect enable, closing DP source and DM sink together.
// - DM between references 20 ms continuously before window end flags forward short.
// - No forward short: end at window close, set done, classify on DM.
// - Forward short with ID present: open probe switches, set done, classify.
// - Forward short, ID open: reverse probe; DP qualified 20 ms flags reverse short.
// - No reverse short by second window end: open pair, set done, classify.
// - Classification combines ID result with bus and data-line results.
// - Bus only, supplies low: no identification, power switch on, hi-Z, boot low.
// - Core up, IO low: identify, mask stays 1, signal switches stay open.
// - Test cable then: test output low-Z; with IO up, UART test sets boot and UART switches, else USB switches.
// - Non-test accessory keeps switches open until host clears the mask.
// - Mask 1 forces interrupt line low; bits still set; host must not read.
// - After mask clear, line stays high one wait time; host waits too.
// - Known attach and wait bit 1 after first delay: second wait, close.
// - Interrupt bits clear on host read; line then returns high.
// - With mask already clear, line goes low as soon as any bit sets.
// - Wait bit 1 at attach: switches close one wait time later.
// - Wait bit 0 at attach: switches stay open until host sets wait bit.
// - ID-open falling edge starts identification; rising edge starts detachment.
// - End of identification sets type bit and attach, or unknown irq.
module charger_detect_and_switch_sequencer #(
    parameter int unsigned DET_STEP_CYC   = chg_seq_pkg::DET_STEP_CYC,
    parameter int unsigned WAIT_STEP_CYC  = chg_seq_pkg::WAIT_STEP_CYC,
    parameter int unsigned SHORT_QUAL_CYC = chg_seq_pkg::SHORT_QUAL_CYC,
    parameter int unsigned WINDOW_CYC     = 2 * chg_seq_pkg::SHORT_QUAL_CYC
) (
    input  wire logic                               REF_CLK,
    input  wire logic                               SRST,
    input  wire logic                               ACTIVE_MODE,
    input  wire logic                               CORE_SUPPLY_OK,
    input  wire logic                               IO_SUPPLY,
    input  wire logic                               BUS_VOLTAGE_DETECTED,
    input  wire logic                               ID_PIN_OPEN_FLAG,
    input  wire logic                               ID_IDENTIFICATION_DONE,
    input  wire logic                               ID_IS_AV_CABLE,
    input  wire logic                               ID_IS_TEST_CABLE,
    input  wire logic                               ID_TEST_IS_UART,
    input  wire logic                               ID_KNOWN,
    input  wire logic                               DM_IN_WINDOW,
    input  wire logic                               DP_IN_WINDOW,
    input  wire logic [chg_seq_pkg::DET_SEL_W-1:0]  DET_DELAY_SEL,
    input  wire logic [chg_seq_pkg::WAIT_SEL_W-1:0] SWITCH_WAIT_SEL,
    input  wire logic                               INT_MASK_WR,
    input  wire logic                               INT_MASK_WDATA,
    input  wire logic                               WAIT_BIT,
    input  wire logic                               IRQ_READ,
    output logic                                    SUPPLY_DETECT_ENABLE,
    output logic                                    DPLUS_SOURCE_SWITCH,
    output logic                                    DMINUS_SINK_SWITCH,
    output logic                                    REVERSE_SOURCE_SWITCH,
    output logic                                    REVERSE_SINK_SWITCH,
    output logic                                    DATA_LINES_FORWARD_SHORTED,
    output logic                                    DATA_LINES_REVERSE_SHORTED,
    output logic                                    BUS_DETECTION_DONE,
    output logic                                    DM_RESULT,
    output logic                                    CLASSIFY_DONE,
    output logic                                    DEVICE_TYPE_AV,
    output logic [chg_seq_pkg::IRQ_W-1:0]           IRQ_BITS,
    output logic                                    INT_MASK,
    output logic                                    HOST_IRQ_N,
    output logic                                    SIGNAL_SWITCHES_ON,
    output logic                                    POWER_SWITCH_ON,
    output logic                                    TEST_CABLE_OUT,
    output logic                                    TEST_CABLE_OE_N,
    output logic                                    CHARGE_CURRENT_SELECT_OUT,
    output logic                                    CHARGE_CURRENT_SELECT_OE_N,
    output logic                                    BOOT_OUT,
    output logic                                    UART_SWITCHES_ON,
    output logic                                    USB_SWITCHES_ON
);
    localparam int unsigned CW = chg_seq_pkg::CNT_W;

    typedef enum logic [3:0] {
        S_IDLE, S_DELAY, S_WAIT_ID, S_PROBE_FWD, S_PROBE_REV, S_CLASSIFY
    } det_state_e;
    typedef enum logic [2:0] {
        W_IDLE, W_FIRST, W_PEND, W_SECOND, W_HOLD, W_CLOSED
    } sw_state_e;

    det_state_e state_r;
    sw_state_e  sw_r;

    initial
    begin
        if (SHORT_QUAL_CYC < 1 || WINDOW_CYC <= SHORT_QUAL_CYC)
            $error("qualification must fit inside the detection window");
        if (DET_STEP_CYC < 1 || WAIT_STEP_CYC < 1)
            $error("step counts must be positive");
    end

    // Pin synchronisers
    logic [1:0] bus_sync_r, idf_sync_r, idd_sync_r, dm_sync_r, dp_sync_r, io_sync_r, core_sync_r;
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            bus_sync_r  <= 2'h0;
            idf_sync_r  <= 2'h3;
            idd_sync_r  <= 2'h0;
            dm_sync_r   <= 2'h0;
            dp_sync_r   <= 2'h0;
            io_sync_r   <= 2'h0;
            core_sync_r <= 2'h0;
        end
        else
        begin
            bus_sync_r  <= {bus_sync_r[0], BUS_VOLTAGE_DETECTED};
            idf_sync_r  <= {idf_sync_r[0], ID_PIN_OPEN_FLAG};
            idd_sync_r  <= {idd_sync_r[0], ID_IDENTIFICATION_DONE};
            dm_sync_r   <= {dm_sync_r[0], DM_IN_WINDOW};
            dp_sync_r   <= {dp_sync_r[0], DP_IN_WINDOW};
            io_sync_r   <= {io_sync_r[0], IO_SUPPLY};
            core_sync_r <= {core_sync_r[0], CORE_SUPPLY_OK};
        end
    end

    logic bus_s, id_open_s, id_done_s, dm_in_s, dp_in_s, io_s, core_s;
    assign bus_s     = bus_sync_r[1];
    assign id_open_s = idf_sync_r[1];
    assign id_done_s = idd_sync_r[1];
    assign dm_in_s   = dm_sync_r[1];
    assign dp_in_s   = dp_sync_r[1];
    assign io_s      = io_sync_r[1];
    assign core_s    = core_sync_r[1];

    // Edge detect on synchronised flags
    logic bus_d_r, idf_d_r;
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            bus_d_r <= 1'b0;
            idf_d_r <= 1'b1;
        end
        else
        begin
            bus_d_r <= bus_s;
            idf_d_r <= id_open_s;
        end
    end

    logic bus_rise, id_attach, id_detach, run_ok;
    assign run_ok    = core_s && ACTIVE_MODE;
    assign bus_rise  = bus_s && !bus_d_r && run_ok;
    assign id_attach = !id_open_s && idf_d_r && core_s;
    assign id_detach = id_open_s && !idf_d_r;

    // Timers built on the internal clock
    logic          det_start, det_done;
    logic [CW-1:0] det_load;
    assign det_load = CW'(({28'h0, DET_DELAY_SEL} + 32'h1) * DET_STEP_CYC);
    tick_timer #(.W(CW)) u_det (
        .clk   (REF_CLK),
        .srst  (SRST),
        .start (det_start),
        .stop  (id_detach),
        .load  (det_load),
        .done  (det_done)
    );

    logic          wt_start, wt_done;
    logic [CW-1:0] wt_load;
    assign wt_load = CW'(({28'h0, SWITCH_WAIT_SEL} + 32'h1) * WAIT_STEP_CYC);
    tick_timer #(.W(CW)) u_wait (
        .clk   (REF_CLK),
        .srst  (SRST),
        .start (wt_start),
        .stop  (id_detach),
        .load  (wt_load),
        .done  (wt_done)
    );

    // Window and qualification counters
    logic [CW-1:0] win_cnt_r, qual_cnt_r;
    logic          win_end, qual_hit, in_win_sel;
    assign win_end    = (win_cnt_r == CW'(WINDOW_CYC - 1));
    assign in_win_sel = (state_r == S_PROBE_REV) ? dp_in_s : dm_in_s;
    assign qual_hit   = in_win_sel && (qual_cnt_r == CW'(SHORT_QUAL_CYC - 1));

    always_ff @(posedge REF_CLK)
    begin
        if (SRST || (state_r != S_PROBE_FWD && state_r != S_PROBE_REV) || qual_hit || win_end)
        begin
            win_cnt_r  <= '0;
            qual_cnt_r <= '0;
        end
        else
        begin
            win_cnt_r  <= win_cnt_r + CW'(1);
            qual_cnt_r <= in_win_sel ? qual_cnt_r + CW'(1) : '0;
        end
    end

    // Detection sequence
    logic saw_id_r;
    assign det_start = bus_rise;
    always_ff @(posedge REF_CLK)
    begin
        if (SRST || id_detach)
        begin
            state_r                    <= S_IDLE;
            saw_id_r                   <= 1'b0;
            SUPPLY_DETECT_ENABLE       <= 1'b0;
            DATA_LINES_FORWARD_SHORTED <= 1'b0;
            DATA_LINES_REVERSE_SHORTED <= 1'b0;
            BUS_DETECTION_DONE         <= 1'b0;
            DM_RESULT                  <= 1'b0;
            CLASSIFY_DONE              <= 1'b0;
            DEVICE_TYPE_AV             <= 1'b0;
        end
        else
        begin
            if (id_attach)
                DEVICE_TYPE_AV <= 1'b0;
            unique case (state_r)
                S_IDLE:
                begin
                    if (bus_rise)
                    begin
                        state_r                    <= S_DELAY;
                        saw_id_r                   <= 1'b0;
                        BUS_DETECTION_DONE         <= 1'b0;
                        CLASSIFY_DONE              <= 1'b0;
                        DATA_LINES_FORWARD_SHORTED <= 1'b0;
                        DATA_LINES_REVERSE_SHORTED <= 1'b0;
                    end
                end
                S_DELAY:
                begin
                    if (!id_open_s)
                        saw_id_r <= 1'b1;
                    if (det_done)
                    begin
                        if (saw_id_r || !id_open_s)
                            state_r <= S_WAIT_ID;
                        else
                        begin
                            state_r              <= S_PROBE_FWD;
                            SUPPLY_DETECT_ENABLE <= 1'b1;
                        end
                    end
                end
                S_WAIT_ID:
                begin
                    if (id_done_s)
                    begin
                        if (ID_IS_AV_CABLE)
                        begin
                            DEVICE_TYPE_AV <= 1'b1;
                            CLASSIFY_DONE  <= 1'b1;
                            state_r        <= S_IDLE;
                        end
                        else
                        begin
                            state_r              <= S_PROBE_FWD;
                            SUPPLY_DETECT_ENABLE <= 1'b1;
                        end
                    end
                end
                S_PROBE_FWD:
                begin
                    if (qual_hit)
                    begin
                        DATA_LINES_FORWARD_SHORTED <= 1'b1;
                        if (!id_open_s)
                        begin
                            SUPPLY_DETECT_ENABLE <= 1'b0;
                            BUS_DETECTION_DONE   <= 1'b1;
                            state_r              <= S_CLASSIFY;
                        end
                        else
                            state_r <= S_PROBE_REV;
                    end
                    else if (win_end)
                    begin
                        DM_RESULT            <= dm_in_s;
                        SUPPLY_DETECT_ENABLE <= 1'b0;
                        BUS_DETECTION_DONE   <= 1'b1;
                        state_r              <= S_CLASSIFY;
                    end
                end
                S_PROBE_REV:
                begin
                    if (qual_hit || win_end)
                    begin
                        DATA_LINES_REVERSE_SHORTED <= qual_hit;
                        SUPPLY_DETECT_ENABLE       <= 1'b0;
                        BUS_DETECTION_DONE         <= 1'b1;
                        state_r                    <= S_CLASSIFY;
                    end
                end
                S_CLASSIFY:
                begin
                    CLASSIFY_DONE <= 1'b1;
                    state_r       <= S_IDLE;
                end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end

    // Probe switches follow state and enable
    assign DPLUS_SOURCE_SWITCH   = SUPPLY_DETECT_ENABLE && (state_r == S_PROBE_FWD);
    assign DMINUS_SINK_SWITCH    = SUPPLY_DETECT_ENABLE && (state_r == S_PROBE_FWD);
    assign REVERSE_SOURCE_SWITCH = SUPPLY_DETECT_ENABLE && (state_r == S_PROBE_REV);
    assign REVERSE_SINK_SWITCH   = SUPPLY_DETECT_ENABLE && (state_r == S_PROBE_REV);

    // Identification end events
    logic id_done_d_r, attach_evt, unknown_evt, av_evt;
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            id_done_d_r <= 1'b0;
        else
            id_done_d_r <= id_done_s;
    end
    assign av_evt      = (state_r == S_WAIT_ID) && id_done_s && ID_IS_AV_CABLE;
    assign attach_evt  = id_done_s && !id_done_d_r && core_s && ID_KNOWN;
    assign unknown_evt = id_done_s && !id_done_d_r && core_s && !ID_KNOWN;

    // Sticky interrupt bits; set wins over read-clear
    logic [chg_seq_pkg::IRQ_W-1:0] irq_set;
    assign irq_set = {unknown_evt, av_evt, attach_evt || av_evt};
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            IRQ_BITS <= '0;
        else
            IRQ_BITS <= (IRQ_READ ? '0 : IRQ_BITS) | irq_set;
    end

    // Mask bit: held at reset value while IO supply is low
    always_ff @(posedge REF_CLK)
    begin
        if (SRST || !io_s)
            INT_MASK <= chg_seq_pkg::INT_MASK_RST;
        else if (INT_MASK_WR)
            INT_MASK <= INT_MASK_WDATA;
    end

    // Switching-wait sequencer; first wait starts from idle once the mask opens, restarts after a detach during it, not after detaches once it has ended
    logic mask_clear, pending, attached_r;
    assign mask_clear = !INT_MASK;
    assign pending    = |IRQ_BITS;
    assign wt_start   = (sw_r == W_IDLE && mask_clear)
                      || (sw_r == W_PEND && attached_r && WAIT_BIT)
                      || (sw_r == W_HOLD && WAIT_BIT);

    always_ff @(posedge REF_CLK)
    begin
        if (SRST || id_detach)
            attached_r <= 1'b0;
        else if (attach_evt)
            attached_r <= 1'b1;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST || INT_MASK)
            sw_r <= W_IDLE;
        else if (id_detach)
            sw_r <= (sw_r == W_IDLE || sw_r == W_FIRST) ? W_IDLE : W_PEND;
        else
        begin
            unique case (sw_r)
                W_IDLE:   sw_r <= W_FIRST;
                W_FIRST:  if (wt_done) sw_r <= W_PEND;
                W_PEND:
                begin
                    if (attached_r)
                        sw_r <= WAIT_BIT ? W_SECOND : W_HOLD;
                end
                W_SECOND: if (wt_done) sw_r <= W_CLOSED;
                W_HOLD:   if (WAIT_BIT) sw_r <= W_SECOND;
                W_CLOSED: sw_r <= W_CLOSED;
                default:  sw_r <= W_IDLE;
            endcase
        end
    end

    // Interrupt line: low under mask, high in first wait, else follows pending
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            HOST_IRQ_N <= 1'b0;
        else if (INT_MASK)
            HOST_IRQ_N <= 1'b0;
        else if (sw_r == W_IDLE || sw_r == W_FIRST)
            HOST_IRQ_N <= 1'b1;
        else
            HOST_IRQ_N <= !((pending && !IRQ_READ) || (|irq_set));
    end

    // Supply-dependent pin behaviour
    logic test_cable;
    assign test_cable = ID_IS_TEST_CABLE && attached_r;
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            SIGNAL_SWITCHES_ON         <= 1'b0;
            UART_SWITCHES_ON           <= 1'b0;
            USB_SWITCHES_ON            <= 1'b0;
            POWER_SWITCH_ON            <= 1'b0;
            TEST_CABLE_OE_N            <= 1'b1;
            CHARGE_CURRENT_SELECT_OE_N <= 1'b1;
            CHARGE_CURRENT_SELECT_OUT  <= 1'b0;
            BOOT_OUT                   <= 1'b0;
        end
        else
        begin
            POWER_SWITCH_ON            <= bus_s;
            CHARGE_CURRENT_SELECT_OE_N <= !(core_s && BUS_DETECTION_DONE);
            CHARGE_CURRENT_SELECT_OUT  <= DM_RESULT;
            TEST_CABLE_OE_N            <= !(core_s && test_cable);
            BOOT_OUT                   <= io_s && test_cable && ID_TEST_IS_UART;
            UART_SWITCHES_ON           <= io_s && test_cable && ID_TEST_IS_UART;
            USB_SWITCHES_ON            <= io_s && test_cable && !ID_TEST_IS_UART;
            SIGNAL_SWITCHES_ON         <= io_s && !test_cable && (sw_r == W_CLOSED);
        end
    end
    assign TEST_CABLE_OUT = 1'b0;
endmodule // charger_detect_and_switch_sequencer

//--- src/chg_seq_pkg.sv
package chg_seq_pkg;
    // Clock rate
    localparam int unsigned CLK_MHZ          = 250;
    // Qualification window for both short tests
    localparam int unsigned SHORT_QUAL_MS    = 20;
    localparam int unsigned SHORT_QUAL_CYC   = SHORT_QUAL_MS * 1000 * CLK_MHZ;
    // Detection-delay and switching-wait step units
    localparam int unsigned DET_STEP_MS      = 100;
    localparam int unsigned DET_STEP_CYC     = DET_STEP_MS * 1000 * CLK_MHZ;
    localparam int unsigned WAIT_STEP_MS     = 10;
    localparam int unsigned WAIT_STEP_CYC    = WAIT_STEP_MS * 1000 * CLK_MHZ;
    // Settings field and counter widths
    localparam int unsigned DET_SEL_W        = 4;
    localparam int unsigned WAIT_SEL_W       = 4;
    localparam int unsigned CNT_W            = 32;
    // Interrupt bit positions
    localparam int unsigned IRQ_W            = 3;
    localparam int unsigned IRQ_ATTACH       = 0;
    localparam int unsigned IRQ_AV_CHG       = 1;
    localparam int unsigned IRQ_UNKNOWN      = 2;
    // Reset values
    localparam logic        INT_MASK_RST     = 1'b1;
endpackage

//--- src/tick_timer.sv
`timescale 1ns/1ps
// Loadable down-counter; done pulses once when the count expires
module tick_timer #(
    parameter int unsigned W = 32
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         start,
    input  wire logic         stop,
    input  wire logic [W-1:0] load,
    output logic              done
);
    logic [W-1:0] cnt_r;
    logic         run_r;

    initial
    begin
        if (W < 2) $error("tick_timer width too small");
    end

    // Count while running, restart on start
    always_ff @(posedge clk)
    begin
        if (srst || stop)
        begin
            cnt_r <= '0;
            run_r <= 1'b0;
            done  <= 1'b0;
        end
        else if (start)
        begin
            cnt_r <= (load == '0) ? W'(1) : load;
            run_r <= 1'b1;
            done  <= 1'b0;
        end
        else if (run_r)
        begin
            done  <= (cnt_r == W'(1));
            run_r <= (cnt_r != W'(1));
            cnt_r <= cnt_r - W'(1);
        end
        else
        begin
            done  <= 1'b0;
        end
    end
endmodule // tick_timer

//--- testbench/chg_seq_properties.sv
`timescale 1ns/1ps
// Port timing relations of the sequencer
module chg_seq_properties (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic IO_SUPPLY,
    input wire logic WAIT_BIT,
    input wire logic INT_MASK,
    input wire logic HOST_IRQ_N,
    input wire logic SUPPLY_DETECT_ENABLE,
    input wire logic DPLUS_SOURCE_SWITCH,
    input wire logic DMINUS_SINK_SWITCH,
    input wire logic REVERSE_SOURCE_SWITCH,
    input wire logic REVERSE_SINK_SWITCH,
    input wire logic BUS_DETECTION_DONE,
    input wire logic SIGNAL_SWITCHES_ON
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    // Probe switches, line masking and signal switches
    a_probe_pair: assert property (DPLUS_SOURCE_SWITCH == DMINUS_SINK_SWITCH)
        else $error("forward probe switches differ");
    a_enable_closes: assert property ($rose(SUPPLY_DETECT_ENABLE) |-> DPLUS_SOURCE_SWITCH)
        else $error("probe enable without source switch");
    a_rev_pair: assert property (REVERSE_SOURCE_SWITCH == REVERSE_SINK_SWITCH
        && !(REVERSE_SOURCE_SWITCH && DPLUS_SOURCE_SWITCH)) else $error("reverse pair fault");
    a_done_opens: assert property (BUS_DETECTION_DONE |-> !DPLUS_SOURCE_SWITCH
        && !REVERSE_SOURCE_SWITCH) else $error("probe switch closed after done");
    a_mask_low: assert property (INT_MASK && $past(INT_MASK) |-> !HOST_IRQ_N)
        else $error("interrupt line released while masked");
    a_unmask_hold: assert property ($fell(INT_MASK) |=> ##1 HOST_IRQ_N [*4])
        else $error("line not held high after unmask");
    a_io_low_open: assert property (!IO_SUPPLY [*4] |-> INT_MASK && !SIGNAL_SWITCHES_ON)
        else $error("switches or mask wrong with io supply low");
    a_wait_gate: assert property ($rose(SIGNAL_SWITCHES_ON) |-> $past(WAIT_BIT)
        || $past(WAIT_BIT, 2)) else $error("switches closed with wait bit low");
endmodule // chg_seq_properties

bind charger_detect_and_switch_sequencer chg_seq_properties u_props (.*);

//--- testbench/host_model.sv
`timescale 1ns/1ps
// Host side: clears the mask on request, reads pending bits when allowed
module host_model (
    input  wire logic clk,
    input  wire logic clear_req,
    input  wire logic read_en,
    input  wire logic irq_n,
    input  wire logic int_mask,
    output logic      mask_wr,
    output logic      irq_read
);
    initial mask_wr = 1'b0;
    initial irq_read = 1'b0;
    // One-cycle mask clear write
    always @(posedge clk) mask_wr <= #1 clear_req;
    // Read only when unmasked, past the delay and asserted
    always @(posedge clk) irq_read <= #1 read_en && !irq_read && !int_mask && !irq_n;
endmodule // host_model

//--- testbench/tb_charger_detect_and_switch_sequencer.sv
`timescale 1ns/1ps
// Bench for the supply detection and switch sequencer
module tb_charger_detect_and_switch_sequencer;
    logic REF_CLK = 0, SRST = 1, ACTIVE_MODE = 0, CORE_SUPPLY_OK = 0, IO_SUPPLY = 0;
    logic BUS_VOLTAGE_DETECTED = 0, ID_PIN_OPEN_FLAG = 0, ID_IDENTIFICATION_DONE = 0;
    logic ID_IS_AV_CABLE = 0, ID_IS_TEST_CABLE = 0, ID_TEST_IS_UART = 0, ID_KNOWN = 1;
    logic DM_IN_WINDOW = 0, DP_IN_WINDOW = 0, INT_MASK_WDATA = 0, WAIT_BIT = 1;
    logic [3:0] DET_DELAY_SEL = 4'h0, SWITCH_WAIT_SEL = 4'h0;
    logic INT_MASK_WR, IRQ_READ, SUPPLY_DETECT_ENABLE, DPLUS_SOURCE_SWITCH, DMINUS_SINK_SWITCH;
    logic REVERSE_SOURCE_SWITCH, REVERSE_SINK_SWITCH, DATA_LINES_FORWARD_SHORTED, DM_RESULT;
    logic DATA_LINES_REVERSE_SHORTED, BUS_DETECTION_DONE, CLASSIFY_DONE, DEVICE_TYPE_AV;
    logic INT_MASK, HOST_IRQ_N, SIGNAL_SWITCHES_ON, POWER_SWITCH_ON, TEST_CABLE_OUT, BOOT_OUT;
    logic TEST_CABLE_OE_N, CHARGE_CURRENT_SELECT_OUT, CHARGE_CURRENT_SELECT_OE_N;
    logic UART_SWITCHES_ON, USB_SWITCHES_ON, clr = 0, rd_en = 0;
    logic [2:0] IRQ_BITS;
    int   err_total = 0, check_count = 0, cyc = 0;

    charger_detect_and_switch_sequencer #(.DET_STEP_CYC(8), .WAIT_STEP_CYC(8),
        .SHORT_QUAL_CYC(4), .WINDOW_CYC(16)) uut (.*);
    host_model host (.clk(REF_CLK), .clear_req(clr), .read_en(rd_en), .irq_n(HOST_IRQ_N),
        .int_mask(INT_MASK), .mask_wr(INT_MASK_WR), .irq_read(IRQ_READ));

    always #2 REF_CLK = ~REF_CLK;
    // Hang guard
    always @(posedge REF_CLK)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask
    function automatic logic cond(input int s);
        case (s)
            0: return BUS_DETECTION_DONE | DEVICE_TYPE_AV;
            1: return !HOST_IRQ_N;
            2: return SIGNAL_SWITCHES_ON;
            default: return HOST_IRQ_N;
        endcase
    endfunction
    // Bounded wait on a completion condition
    task automatic wait_on(input int s);
        int n;
        n = 0;
        while (cond(s) !== 1'b1 && n < 400)
        begin
            tick(1);
            n++;
        end
        if (n == 400)
            chk("wait", 4'h1, 4'h0);
    endtask
    // One bus attach with given line levels and cable kind
    task automatic detect(input logic m, input logic p, input logic a, input logic [3:0] d);
        BUS_VOLTAGE_DETECTED = 0;
        ID_IDENTIFICATION_DONE = 0;
        DM_IN_WINDOW = m;
        DP_IN_WINDOW = p;
        ID_IS_AV_CABLE = a;
        DET_DELAY_SEL = d;
        tick(6);
        BUS_VOLTAGE_DETECTED = 1;
        tick(4);
        ID_IDENTIFICATION_DONE = 1;
        wait_on(0);
        tick(2);
    endtask

    initial
    begin
        tick(12);
        chk("irq_n", 4'h0, HOST_IRQ_N);
        chk("mask", 4'h1, INT_MASK);
        SRST = 0;
        ACTIVE_MODE = 1;
        CORE_SUPPLY_OK = 1;
        IO_SUPPLY = 1;
        detect(0, 0, 0, 4'h0);
        chk("fwd", 4'h0, DATA_LINES_FORWARD_SHORTED);
        chk("done", 4'h1, BUS_DETECTION_DONE);
        chk("cls", 4'h1, CLASSIFY_DONE);
        detect(1, 0, 0, 4'h1);
        chk("fwd", 4'h1, DATA_LINES_FORWARD_SHORTED);
        chk("rev", 4'h0, DATA_LINES_REVERSE_SHORTED);
        ID_PIN_OPEN_FLAG = 1;
        detect(1, 1, 0, 4'h0);
        chk("rev", 4'h1, DATA_LINES_REVERSE_SHORTED);
        detect(1, 0, 0, 4'h0);
        chk("rev", 4'h0, DATA_LINES_REVERSE_SHORTED);
        chk("done", 4'h1, BUS_DETECTION_DONE);
        ID_PIN_OPEN_FLAG = 0;
        detect(0, 0, 1, 4'h0);
        chk("irq_av", 4'h1, IRQ_BITS[chg_seq_pkg::IRQ_AV_CHG]);
        chk("irq_att", 4'h1, IRQ_BITS[chg_seq_pkg::IRQ_ATTACH]);
        chk("type_av", 4'h1, DEVICE_TYPE_AV);
        chk("irq_n", 4'h0, HOST_IRQ_N);
        chk("sw", 4'h0, SIGNAL_SWITCHES_ON);
        clr = 1;
        tick(1);
        clr = 0;
        tick(4);
        chk("irq_n", 4'h1, HOST_IRQ_N);
        wait_on(1);
        chk("sw", 4'h0, SIGNAL_SWITCHES_ON);
        wait_on(2);
        rd_en = 1;
        wait_on(3);
        rd_en = 0;
        tick(2);
        chk("irq", 4'h0, IRQ_BITS);
        WAIT_BIT = 0;
        ID_PIN_OPEN_FLAG = 1;
        tick(4);
        ID_PIN_OPEN_FLAG = 0;
        detect(0, 0, 1, 4'h0);
        wait_on(1);
        chk("sw", 4'h0, SIGNAL_SWITCHES_ON);
        WAIT_BIT = 1;
        wait_on(2);
        IO_SUPPLY = 0;
        tick(6);
        chk("mask", 4'h1, INT_MASK);
        chk("sw", 4'h0, SIGNAL_SWITCHES_ON);
        ID_IS_TEST_CABLE = 1;
        ID_TEST_IS_UART = 1;
        tick(2);
        chk("test_oe", 4'h0, TEST_CABLE_OE_N);
        chk("test_out", 4'h0, TEST_CABLE_OUT);
        chk("uart", 4'h0, UART_SWITCHES_ON);
        IO_SUPPLY = 1;
        tick(4);
        chk("boot", 4'h1, BOOT_OUT);
        chk("uart", 4'h1, UART_SWITCHES_ON);
        chk("usb", 4'h0, USB_SWITCHES_ON);
        IO_SUPPLY = 0;
        CORE_SUPPLY_OK = 0;
        tick(6);
        chk("pwr", 4'h1, POWER_SWITCH_ON);
        chk("charge_current_select_out_oe", 4'h1, CHARGE_CURRENT_SELECT_OE_N);
        chk("test_oe", 4'h1, TEST_CABLE_OE_N);
        chk("boot", 4'h0, BOOT_OUT);
        finish_test();
    end
endmodule // tb_charger_detect_and_switch_sequencer
